// file: core/status_service_request_pkg.sv
// package for the status and service request block
// holds field positions, reset values, timing counts and operation codes
package status_service_request_pkg;

	// register widths
	localparam int REG_W = 8;
	localparam int IDX_W = 4;

	// status summary byte bit positions
	localparam int SUM_BIT_COMM     = 0;
	localparam int SUM_BIT_OVERLOAD = 1;
	localparam int SUM_BIT_EVENT    = 5;
	localparam int SUM_BIT_REQUEST  = 6;

	// highest valid bit index
	localparam logic [IDX_W-1:0] MAX_BIT_INDEX = 4'h7;

	// reset values
	localparam logic [REG_W-1:0] FLAGS_RESET = 8'h00;
	localparam logic [REG_W-1:0] MASK_RESET  = 8'h00;
	localparam logic             PULSE_MODE_RESET = 1'b0;

	// pulse timing: least low time of the request line
	localparam int CLK_MHZ       = 200;
	localparam int PULSE_MIN_NS  = 1000;
	localparam int PULSE_CYCLES  = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int PULSE_CNT_W   = 8;

	// operation targets
	typedef enum logic [3:0] {
		SEL_NONE      = 4'h0,
		SEL_SUMMARY   = 4'h1,
		SEL_SUM_MASK  = 4'h2,
		SEL_EVENT     = 4'h3,
		SEL_EVT_MASK  = 4'h4,
		SEL_COMM      = 4'h5,
		SEL_COMM_MASK = 4'h6,
		SEL_OVL_COND  = 4'h7,
		SEL_OVL_LATCH = 4'h8,
		SEL_OVL_MASK  = 4'h9,
		SEL_PULSE     = 4'hA
	} target_sel_t;

	// request line states
	typedef enum logic [1:0] {
		LINE_IDLE  = 2'b00,
		LINE_LATCH = 2'b01,
		LINE_PULSE = 2'b10
	} line_state_t;

endpackage

// file: core/event_group.sv
// one event group: sticky flags, enable mask, read-clears-returned-bits
// assumes one operation per cycle from the command interpreter
`timescale 1ns/1ps
module event_group
	import status_service_request_pkg::*;
(
	// clock and reset
	input  wire logic             mclk_i,
	input  wire logic             rst_n_i,
	// event sources
	input  wire logic [REG_W-1:0] set_i,
	input  wire logic             clear_all_i,
	// flag read (clears returned bits)
	input  wire logic             flag_rd_i,
	input  wire logic [REG_W-1:0] flag_rd_bits_i,
	// mask write
	input  wire logic             mask_wr_i,
	input  wire logic [REG_W-1:0] mask_wr_bits_i,
	input  wire logic [REG_W-1:0] mask_wr_data_i,
	// state
	output logic      [REG_W-1:0] flags_o,
	output logic      [REG_W-1:0] mask_o,
	output logic                  summary_o
);

	logic [REG_W-1:0] next_flags;
	logic [REG_W-1:0] next_mask;

	// next flags: clear returned bits, new events win
	always_comb begin
		next_flags = flags_o;
		if (clear_all_i) begin
			next_flags = FLAGS_RESET;
		end else if (flag_rd_i) begin
			next_flags = flags_o & ~flag_rd_bits_i;
		end
		next_flags = next_flags | set_i;
		next_mask = (mask_o & ~mask_wr_bits_i) | (mask_wr_data_i & mask_wr_bits_i);
		if (!mask_wr_i) begin
			next_mask = mask_o;
		end
	end

	// register flags and mask
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			flags_o <= FLAGS_RESET;
			mask_o  <= MASK_RESET;
		end else begin
			flags_o <= next_flags;
			mask_o  <= next_mask;
		end
	end

	assign summary_o = |(flags_o & mask_o);

endmodule // event_group

// file: core/status_service_request.sv
// status reporting and service request logic of the instrument module
// assumes a command interpreter presents one decoded operation per cycle
// Functional notes
// - whole summary read releases request line in latch mode
// - single-bit summary read leaves line alone
// - summary query returns byte or bit
// - summary mask settable/readable, whole or bit
// - event flag query returns byte or bit
// - event flag read clears returned bits
// - event mask settable/readable, whole or bit
// - comm error read clears returned bits
// - comm mask settable/readable, whole or bit
// - overload condition query returns live bits
// - latched overload read clears returned bits
// - pulse mode: low pulse at least 1us
// - latch mode: low until whole summary read
// - pulse mode one bit, off at reset
// - clear command zeroes all event flags, except bits whose source sets them in the same cycle
// - summary bit index above 7 rejected
`timescale 1ns/1ps
module status_service_request
	import status_service_request_pkg::*;
(
	// clock and reset
	input  wire logic             mclk_i,
	input  wire logic             rst_n_i,
	// operation from the command interpreter
	input  wire logic             op_valid_i,
	input  wire logic             op_write_i,
	input  wire logic [3:0]       op_target_i,
	input  wire logic             op_indexed_i,
	input  wire logic [IDX_W-1:0] op_index_i,
	input  wire logic [REG_W-1:0] op_data_i,
	input  wire logic             clear_all_flags_cmd_i,
	// event sources
	input  wire logic [REG_W-1:0] standard_event_set_i,
	input  wire logic [REG_W-1:0] comm_error_set_i,
	input  wire logic [REG_W-1:0] overload_condition_bits_i,
	input  wire logic [REG_W-1:0] summary_aux_bits_i,
	// answer
	output logic                  resp_valid_o,
	output logic      [REG_W-1:0] resp_data_o,
	output logic                  invalid_bit_err_o,
	// service request line and mode
	output logic                  service_request_n_o,
	output logic                  request_pulse_mode_o
);

	////////////////////////////////////////////////////////////////////////
	// operation decode

	target_sel_t      sel;
	logic             rd;
	logic             wr;
	logic             idx_bad;
	logic [REG_W-1:0] bits;
	logic [REG_W-1:0] wdata;

	// decode target, lane mask and write data
	always_comb begin
		sel     = target_sel_t'(op_target_i);
		rd      = op_valid_i & ~op_write_i;
		wr      = op_valid_i & op_write_i;
		idx_bad = op_indexed_i && (op_index_i > MAX_BIT_INDEX);
		bits    = 8'hFF;
		wdata   = op_data_i;
		if (op_indexed_i) begin
			bits  = 8'h01 << op_index_i[2:0];
			wdata = op_data_i[0] ? bits : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// event groups

	logic [REG_W-1:0] standard_event_flags;
	logic [REG_W-1:0] standard_event_enable_mask;
	logic [REG_W-1:0] comm_error_flags;
	logic [REG_W-1:0] comm_error_enable_mask;
	logic [REG_W-1:0] overload_latched_flags;
	logic [REG_W-1:0] overload_enable_mask;
	logic             evt_sum;
	logic             comm_sum;
	logic             ovl_sum;
	logic             ok;

	assign ok = ~idx_bad;

	event_group u_event (
		.mclk_i         (mclk_i),
		.rst_n_i        (rst_n_i),
		.set_i          (standard_event_set_i),
		.clear_all_i    (clear_all_flags_cmd_i),
		.flag_rd_i      (rd & ok & (sel == SEL_EVENT)),
		.flag_rd_bits_i (bits),
		.mask_wr_i      (wr & ok & (sel == SEL_EVT_MASK)),
		.mask_wr_bits_i (bits),
		.mask_wr_data_i (wdata),
		.flags_o        (standard_event_flags),
		.mask_o         (standard_event_enable_mask),
		.summary_o      (evt_sum)
	);

	event_group u_comm (
		.mclk_i         (mclk_i),
		.rst_n_i        (rst_n_i),
		.set_i          (comm_error_set_i),
		.clear_all_i    (clear_all_flags_cmd_i),
		.flag_rd_i      (rd & ok & (sel == SEL_COMM)),
		.flag_rd_bits_i (bits),
		.mask_wr_i      (wr & ok & (sel == SEL_COMM_MASK)),
		.mask_wr_bits_i (bits),
		.mask_wr_data_i (wdata),
		.flags_o        (comm_error_flags),
		.mask_o         (comm_error_enable_mask),
		.summary_o      (comm_sum)
	);

	event_group u_ovl (
		.mclk_i         (mclk_i),
		.rst_n_i        (rst_n_i),
		.set_i          (overload_condition_bits_i),
		.clear_all_i    (clear_all_flags_cmd_i),
		.flag_rd_i      (rd & ok & (sel == SEL_OVL_LATCH)),
		.flag_rd_bits_i (bits),
		.mask_wr_i      (wr & ok & (sel == SEL_OVL_MASK)),
		.mask_wr_bits_i (bits),
		.mask_wr_data_i (wdata),
		.flags_o        (overload_latched_flags),
		.mask_o         (overload_enable_mask),
		.summary_o      (ovl_sum)
	);

	////////////////////////////////////////////////////////////////////////
	// summary byte and enable mask

	logic [REG_W-1:0] status_summary_byte;
	logic [REG_W-1:0] summary_enable_mask;
	logic [REG_W-1:0] next_summary_enable_mask;
	logic             next_pulse_mode;
	logic             request_now;
	logic             request_prev;
	logic             next_request_prev;
	logic             new_request;

	always_comb begin
		status_summary_byte = summary_aux_bits_i;
		status_summary_byte[SUM_BIT_COMM]     = comm_sum;
		status_summary_byte[SUM_BIT_OVERLOAD] = ovl_sum;
		status_summary_byte[SUM_BIT_EVENT]    = evt_sum;
		status_summary_byte[SUM_BIT_REQUEST]  = ~service_request_n_o;
		request_now = |(status_summary_byte & summary_enable_mask
			& ~(8'h01 << SUM_BIT_REQUEST));
		new_request = request_now & ~request_prev;
		next_request_prev = request_now;
	end

	always_comb begin
		next_summary_enable_mask = summary_enable_mask;
		next_pulse_mode          = request_pulse_mode_o;
		if (wr && ok && (sel == SEL_SUM_MASK)) begin
			next_summary_enable_mask = (summary_enable_mask & ~bits) | (wdata & bits);
		end
		if (wr && (sel == SEL_PULSE)) begin
			next_pulse_mode = op_data_i[0];
		end
	end

	// register mask, mode and request history
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			summary_enable_mask  <= MASK_RESET;
			request_pulse_mode_o <= PULSE_MODE_RESET;
			request_prev         <= 1'b0;
		end else begin
			summary_enable_mask  <= next_summary_enable_mask;
			request_pulse_mode_o <= next_pulse_mode;
			request_prev         <= next_request_prev;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// service request line

	line_state_t            line_state;
	line_state_t            next_line_state;
	logic [PULSE_CNT_W-1:0] pulse_cnt;
	logic [PULSE_CNT_W-1:0] next_pulse_cnt;
	logic                   whole_sum_read;

	assign whole_sum_read = rd & (sel == SEL_SUMMARY) & ~op_indexed_i;

	// line state machine
	always_comb begin
		next_line_state = line_state;
		next_pulse_cnt  = pulse_cnt;
		case (line_state)
			LINE_IDLE: begin
				if (new_request && request_pulse_mode_o) begin
					next_line_state = LINE_PULSE;
					next_pulse_cnt  = PULSE_CNT_W'(PULSE_CYCLES - 1);
				end else if (new_request) begin
					next_line_state = LINE_LATCH;
				end
			end
			LINE_LATCH: begin
				if (whole_sum_read) begin
					next_line_state = LINE_IDLE;
				end
			end
			LINE_PULSE: begin
				if (pulse_cnt == '0) begin
					next_line_state = LINE_IDLE;
				end else begin
					next_pulse_cnt = pulse_cnt - 1'b1;
				end
			end
			default: begin
				next_line_state = LINE_IDLE;
			end
		endcase
	end

	// register line state, output straight from a flop
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			line_state          <= LINE_IDLE;
			pulse_cnt           <= '0;
			service_request_n_o <= 1'b1;
		end else begin
			line_state          <= next_line_state;
			pulse_cnt           <= next_pulse_cnt;
			service_request_n_o <= (next_line_state == LINE_IDLE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// query answers

	logic [REG_W-1:0] rd_value;
	logic             next_resp_valid;
	logic [REG_W-1:0] next_resp_data;
	logic             next_err;

	always_comb begin
		rd_value = 8'h00;
		if (sel == SEL_SUMMARY) begin
			rd_value = status_summary_byte;
		end else if (sel == SEL_SUM_MASK) begin
			rd_value = summary_enable_mask;
		end else if (sel == SEL_EVENT) begin
			rd_value = standard_event_flags;
		end else if (sel == SEL_EVT_MASK) begin
			rd_value = standard_event_enable_mask;
		end else if (sel == SEL_COMM) begin
			rd_value = comm_error_flags;
		end else if (sel == SEL_COMM_MASK) begin
			rd_value = comm_error_enable_mask;
		end else if (sel == SEL_OVL_COND) begin
			rd_value = overload_condition_bits_i;
		end else if (sel == SEL_OVL_LATCH) begin
			rd_value = overload_latched_flags;
		end else if (sel == SEL_OVL_MASK) begin
			rd_value = overload_enable_mask;
		end else if (sel == SEL_PULSE) begin
			rd_value = {7'h00, request_pulse_mode_o};
		end
		next_resp_valid = rd & ok;
		next_resp_data  = 8'h00;
		if (rd && ok) begin
			next_resp_data = op_indexed_i ? {7'h00, |(rd_value & bits)} : rd_value;
		end
		next_err = op_valid_i & idx_bad;
	end

	// register answers
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			resp_valid_o      <= 1'b0;
			resp_data_o       <= 8'h00;
			invalid_bit_err_o <= 1'b0;
		end else begin
			resp_valid_o      <= next_resp_valid;
			resp_data_o       <= next_resp_data;
			invalid_bit_err_o <= next_err;
		end
	end

endmodule // status_service_request

// file: tb/status_service_request_sva.sv
// assertions on the status and service request block
// sees only the top ports; bound to every instance below
`timescale 1ns/1ps
module status_service_request_sva
	import status_service_request_pkg::*;
(
	// clock, reset and operation
	input wire logic             mclk_i,
	input wire logic             rst_n_i,
	input wire logic             op_valid_i,
	input wire logic             op_write_i,
	input wire logic [3:0]       op_target_i,
	input wire logic             op_indexed_i,
	input wire logic [IDX_W-1:0] op_index_i,
	input wire logic [REG_W-1:0] op_data_i,
	// event sources
	input wire logic [REG_W-1:0] standard_event_set_i,
	input wire logic [REG_W-1:0] comm_error_set_i,
	input wire logic [REG_W-1:0] overload_condition_bits_i,
	input wire logic [REG_W-1:0] summary_aux_bits_i,
	// answer and line
	input wire logic             resp_valid_o,
	input wire logic [REG_W-1:0] resp_data_o,
	input wire logic             invalid_bit_err_o,
	input wire logic             service_request_n_o,
	input wire logic             request_pulse_mode_o
);
	// decoded operation kinds
	wire logic rd = op_valid_i && !op_write_i;
	wire logic bad = op_indexed_i && (op_index_i > MAX_BIT_INDEX);
	wire logic whole_sum = rd && op_target_i == 4'h1 && !op_indexed_i;
	wire logic mode_op = op_valid_i && op_target_i == 4'hA;
	wire logic data_lsb = op_data_i[0];
	wire logic quiet = (standard_event_set_i | comm_error_set_i | overload_condition_bits_i | summary_aux_bits_i) == 8'h00;

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	////////////////////////////////////////////////////////////////
	a_query_answer: assert property (rd && !bad && !mode_op |=> resp_valid_o && !invalid_bit_err_o)
		else $error("query not answered next cycle");
	a_index_reject: assert property (op_valid_i && bad && !mode_op |=> invalid_bit_err_o && !resp_valid_o)
		else $error("bad index not rejected");
	a_answer_idle: assert property (!op_valid_i |=> !resp_valid_o && resp_data_o == 8'h00)
		else $error("answer without query");
	a_cond_live: assert property (rd && op_target_i == 4'h7 && !op_indexed_i |=> resp_data_o == $past(overload_condition_bits_i))
		else $error("condition read not live");
	a_whole_release: assert property (whole_sum && !request_pulse_mode_o && quiet |=> service_request_n_o)
		else $error("whole read kept line low");
	a_latch_hold: assert property (!request_pulse_mode_o && !service_request_n_o && !whole_sum && !mode_op |=> !service_request_n_o)
		else $error("latched line released early");
	a_pulse_width: assert property ($fell(service_request_n_o) && request_pulse_mode_o |-> (!service_request_n_o throughout ##199 1'b1) ##1 service_request_n_o)
		else $error("pulse width wrong");
	a_mode_reset: assert property ($rose(rst_n_i) |-> !request_pulse_mode_o && service_request_n_o)
		else $error("reset state wrong");
	a_mode_write: assert property (mode_op && op_write_i |=> request_pulse_mode_o == $past(data_lsb))
		else $error("pulse mode not written");
endmodule // status_service_request_sva

bind status_service_request status_service_request_sva u_sva (.mclk_i, .rst_n_i, .op_valid_i, .op_write_i,
	.op_target_i, .op_indexed_i, .op_index_i, .op_data_i, .standard_event_set_i, .comm_error_set_i,
	.overload_condition_bits_i, .summary_aux_bits_i, .resp_valid_o, .resp_data_o, .invalid_bit_err_o,
	.service_request_n_o, .request_pulse_mode_o);

// file: tb/host_line_monitor.sv
// host model watching the active-low request line
// samples on the block clock; the line idles high
`timescale 1ns/1ps
module host_line_monitor (
	// clock and line
	input  wire logic mclk_i,
	input  wire logic service_request_n_i,
	// requests seen and last low span in cycles
	output int        fall_count_o,
	output int        low_width_o
);
	int run;

	initial begin
		fall_count_o = 0;
		low_width_o = 0;
		run = 0;
	end

	// count each new request and measure its low span
	always @(posedge mclk_i) begin
		if (!service_request_n_i) begin
			if (run == 0)
				fall_count_o <= fall_count_o + 1;
			run <= run + 1;
		end else begin
			if (run != 0)
				low_width_o <= run;
			run <= 0;
		end
	end
endmodule // host_line_monitor

// file: tb/tb_top.sv
// self-checking bench for the status and service request block
// one decoded operation at a time; host model watches the line
`timescale 1ns/1ps
module tb_top;
	import status_service_request_pkg::*;
	logic       mclk_i = 1'b0;
	logic       rst_n_i, op_valid_i, op_write_i, op_indexed_i, clear_all_flags_cmd_i, rv, re;
	logic [3:0] op_target_i, op_index_i;
	logic [7:0] op_data_i, standard_event_set_i, comm_error_set_i, overload_condition_bits_i, summary_aux_bits_i, rsp;
	logic       resp_valid_o, invalid_bit_err_o, service_request_n_o, request_pulse_mode_o;
	logic [7:0] resp_data_o;
	logic [3:0] mtg[4] = '{4'h2, 4'h4, 4'h6, 4'h9};
	logic [3:0] ftg[3] = '{4'h3, 4'h5, 4'h8};
	int         err_total = 0, num_checks = 0, falls, fall_count, low_width;

	status_service_request u_dut (.mclk_i, .rst_n_i, .op_valid_i, .op_write_i, .op_target_i, .op_indexed_i,
		.op_index_i, .op_data_i, .clear_all_flags_cmd_i, .standard_event_set_i, .comm_error_set_i,
		.overload_condition_bits_i, .summary_aux_bits_i, .resp_valid_o, .resp_data_o, .invalid_bit_err_o,
		.service_request_n_o, .request_pulse_mode_o);
	host_line_monitor u_host (.mclk_i, .service_request_n_i(service_request_n_o),
		.fall_count_o(fall_count), .low_width_o(low_width));

	// clock and watchdog
	always #2.5 mclk_i = ~mclk_i;
	initial begin
		#50000;
		err_total++;
		summarize();
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", what, exp, got);
		end
	endtask

	// launch, hold over the taking edge, capture the answer
	task automatic op(input logic w, input logic [3:0] tg, input logic ix, input logic [3:0] id, input logic [7:0] d);
		@(posedge mclk_i);
		#1;
		{op_valid_i, op_write_i, op_target_i, op_indexed_i, op_index_i, op_data_i} = {1'b1, w, tg, ix, id, d};
		@(posedge mclk_i);
		#1;
		op_valid_i = 1'b0;
		{rv, re, rsp} = {resp_valid_o, invalid_bit_err_o, resp_data_o};
	endtask

	// one-cycle event and clear pulses
	task automatic fire(input logic [7:0] e, input logic [7:0] c, input logic [7:0] o, input logic clr);
		@(posedge mclk_i);
		#1;
		{standard_event_set_i, comm_error_set_i, overload_condition_bits_i, clear_all_flags_cmd_i} = {e, c, o, clr};
		@(posedge mclk_i);
		#1;
		{standard_event_set_i, comm_error_set_i, overload_condition_bits_i, clear_all_flags_cmd_i} = 25'h0;
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		{rst_n_i, op_valid_i, op_write_i, op_indexed_i, clear_all_flags_cmd_i, op_target_i, op_index_i} = 0;
		{op_data_i, standard_event_set_i, comm_error_set_i, overload_condition_bits_i, summary_aux_bits_i} = 0;
		repeat (16) @(posedge mclk_i);
		#1;
		rst_n_i = 1'b1;
		chk("reset state", 8'h01, {request_pulse_mode_o, service_request_n_o});
		foreach (mtg[k]) begin
			op(1, mtg[k], 0, 0, 8'hA5);
			op(1, mtg[k], 1, 4'h1, 8'h01);
			op(0, mtg[k], 0, 0, 0);
			chk("mask whole", 8'hA7, rsp);
			op(0, mtg[k], 1, 4'h7, 0);
			chk("mask bit", 8'h01, rsp);
			op(1, mtg[k], 0, 0, 0);
		end
		fire(8'h81, 8'h81, 8'h81, 0);
		foreach (ftg[k]) begin
			op(0, ftg[k], 1, 4'h7, 0);
			chk("flag bit", 8'h01, rsp);
			op(0, ftg[k], 0, 0, 0);
			chk("flag rest", 8'h01, rsp);
			op(0, ftg[k], 0, 0, 0);
			chk("flag cleared", 8'h00, rsp);
		end
		overload_condition_bits_i = 8'h3C;
		op(0, 4'h7, 0, 0, 0);
		chk("cond live", 8'h3C, rsp);
		overload_condition_bits_i = 8'h00;
		fire(8'h0F, 8'h0F, 8'h00, 0);
		fire(0, 0, 0, 1);
		foreach (ftg[k]) begin
			op(0, ftg[k], 0, 0, 0);
			chk("clear cmd", 8'h00, rsp);
		end
		op(1, 4'h2, 1, 4'h8, 8'h01);
		chk("bad index", 8'h01, {rv, re});
		op(0, 4'h2, 0, 0, 0);
		chk("bad index no write", 8'h00, rsp);
		op(1, 4'h4, 0, 0, 8'h01);
		op(1, 4'h2, 0, 0, 8'h20);
		falls = fall_count;
		fire(8'h01, 0, 0, 0);
		op(0, 4'h1, 1, 4'h5, 0);
		chk("summary bit", 8'h01, rsp);
		chk("line kept", 8'h00, {7'h0, service_request_n_o});
		op(0, 4'h1, 0, 0, 0);
		chk("summary byte", 8'h20, rsp & 8'hBF);
		chk("line released", 8'h01, {7'h0, service_request_n_o});
		chk("one request", 8'h01, 8'(fall_count - falls));
		op(0, 4'h3, 0, 0, 0);
		op(1, 4'hA, 0, 0, 8'h01);
		op(0, 4'hA, 0, 0, 0);
		chk("pulse mode", 8'h01, rsp);
		op(1, 4'h6, 0, 0, 8'h01);
		op(1, 4'h2, 0, 0, 8'h01);
		falls = fall_count;
		fire(0, 8'h01, 0, 0);
		repeat (260) @(posedge mclk_i);
		#1;
		chk("pulse count", 8'h01, 8'(fall_count - falls));
		chk("pulse width", 8'hC8, 8'(low_width));
		chk("line after pulse", 8'h01, {7'h0, service_request_n_o});
		summary_aux_bits_i = 8'h84;
		op(0, 4'h1, 0, 0, 0);
		chk("summary aux", 8'h85, rsp);
		op(0, 4'h5, 1, 4'h8, 0);
		chk("bad read", 8'h01, {rv, re});
		op(0, 4'h5, 0, 0, 0);
		chk("bad read no clear", 8'h01, rsp);
		summarize();
	end
endmodule // tb_top
